// ### hw/flt_pkg.sv
// flt_pkg: constants for the fan speed table entries five and six.
// assumes one 200 MHz clock; registers sit on an Avalon-MM word bus.
package flt_pkg;

  // register indices, byte address is four times the index
  localparam logic [7:0] IDX_TABLE_CTRL = 8'h4A;
  localparam logic [7:0] IDX_TEMP_OFS   = 8'h4E;
  localparam logic [7:0] IDX_DUTY_FIVE  = 8'h59;
  localparam logic [7:0] IDX_TEMP_SIX   = 8'h5A;
  localparam logic [7:0] IDX_DUTY_SIX   = 8'h5B;
  localparam logic [7:0] IDX_PWM_CFG    = 8'h60;

  // table control fields
  localparam int CTRL_TEMP_HIRES = 0;
  localparam int CTRL_DUTY_HIRES = 1;
  localparam int CTRL_UNLOCK     = 5;
  localparam logic [7:0] CTRL_WMASK = 8'h23;

  // pwm config: frequency select field
  localparam int PWM_FREQ_LSB = 0;
  localparam int PWM_FREQ_W   = 3;
  localparam logic [2:0] PWM_FREQ_22K5 = 3'h7;

  // duty and limit field positions
  localparam int DUTY_EXT_MSB  = 7;
  localparam int DUTY_EXT_LSB  = 6;
  localparam int DUTY_BASE_MSB = 5;
  localparam int LIMIT_HALF    = 7;
  localparam int LIMIT_INT_MSB = 6;

  // reset values
  localparam logic [7:0] RST_DUTY_FIVE = 8'h3F;
  localparam logic [7:0] RST_TEMP_SIX  = 8'h7F;
  localparam logic [7:0] RST_DUTY_SIX  = 8'h3F;
  localparam logic [7:0] RST_CTRL      = 8'h00;
  localparam logic [7:0] RST_OFS       = 8'h00;
  localparam logic [7:0] RST_PWM_CFG   = 8'h00;

  typedef enum logic [1:0] {
    FLT_IDLE = 2'b01,
    FLT_RESP = 2'b10
  } flt_bus_e;

endpackage : flt_pkg

// ### hw/flt_entry.sv
// flt_entry: decode of one table entry, limit compare and duty value.
// assumes temperature in half-degree steps, bits [8:1] whole degrees.
`timescale 1ns/1ps
`default_nettype none
module flt_entry
  import flt_pkg::*;
(
  input  wire logic       temp_hires,  // 9-bit compare mode
  input  wire logic       duty_hires,  // 8-bit duty mode when freq_22k5
  input  wire logic       freq_22k5,   // pwm frequency allows ext bits
  input  wire logic [7:0] limit_raw,   // stored limit entry
  input  wire logic [7:0] duty_raw,    // stored duty entry
  input  wire logic [7:0] offset,      // table temperature offset
  input  wire logic [8:0] temp,        // remote temperature
  output logic            exceeded,    // temp above limit
  output logic      [7:0] duty_eff     // duty value in force
);

  logic [9:0] limit_half;
  logic [9:0] temp_half;
  logic       ext_on;

  always_comb begin
    // sign bit never stored: limit is always positive
    limit_half = {2'b00, limit_raw[LIMIT_INT_MSB:0], 1'b0};
    if (temp_hires) begin
      limit_half[0] = limit_raw[LIMIT_HALF];
    end
    limit_half = limit_half + {1'b0, offset, 1'b0};
    // low resolution drops the half-degree bit of the reading
    temp_half = temp_hires ? {1'b0, temp} : {1'b0, temp[8:1], 1'b0};
    exceeded  = temp_half > limit_half;
    ext_on    = duty_hires && freq_22k5;
    if (ext_on) begin
      duty_eff = duty_raw;
    end else begin
      duty_eff = {2'b00, duty_raw[DUTY_BASE_MSB:0]};
    end
  end

endmodule : flt_entry
`default_nettype wire

// ### hw/flt_top.sv
// flt_top: fan speed table entries five and six with their compare.
// assumes a synchronous Avalon-MM master and a remote temperature
// reading already synchronous to CLOCK.
`timescale 1ns/1ps
`default_nettype none
module flt_top
  import flt_pkg::*;
#(
  parameter int ADDR_W = 10
)
(
  input  wire logic              CLOCK,          // 200 MHz clock
  input  wire logic              NRST,           // async reset, low
  input  wire logic [ADDR_W-1:0] ADDRESS,        // byte address
  input  wire logic              READ,           // read request
  input  wire logic              WRITE,          // write request
  input  wire logic [3:0]        BYTEENABLE,     // byte lanes
  input  wire logic [31:0]       WRITEDATA,      // write data
  output logic      [31:0]       READDATA,       // read data
  output logic                   WAITREQUEST,    // stall, high busy
  input  wire logic [8:0]        REMOTE_TEMP,    // half-degree units
  input  wire logic [7:0]        LIMIT_FIVE,     // entry five limit
  output logic      [7:0]        PWM_DUTY,       // selected duty
  output logic                   PWM_VALID,      // a limit is exceeded
  output logic                   LIMIT_FIVE_HIT, // above entry five
  output logic                   LIMIT_SIX_HIT   // above entry six
);

  typedef struct packed {
    flt_bus_e   st;
    logic       waitreq;
    logic [7:0] rdata;
    logic [7:0] duty_five;
    logic [7:0] temp_six;
    logic [7:0] duty_six;
    logic [7:0] ctrl;
    logic [7:0] ofs;
    logic [7:0] pwm_cfg;
    logic [7:0] pwm_duty;
    logic       pwm_valid;
    logic       hit_five;
    logic       hit_six;
  } flt_state_s;

  flt_state_s r;
  flt_state_s next_r;

  logic [7:0] idx;
  logic       temp_hires;
  logic       duty_hires;
  logic       freq_22k5;
  logic       unlocked;
  logic       exceed_five;
  logic       exceed_six;
  logic [7:0] duty_eff_five;
  logic [7:0] duty_eff_six;
  logic       wr_lane;
  logic [7:0] wbyte;

  assign idx        = ADDRESS[ADDR_W-1:2];
  assign temp_hires = r.ctrl[CTRL_TEMP_HIRES];
  assign duty_hires = r.ctrl[CTRL_DUTY_HIRES];
  assign unlocked   = r.ctrl[CTRL_UNLOCK];
  assign freq_22k5  =
    r.pwm_cfg[PWM_FREQ_LSB +: PWM_FREQ_W] == PWM_FREQ_22K5;
  assign wr_lane    = BYTEENABLE[0];
  assign wbyte      = WRITEDATA[7:0];

  flt_entry u_entry_five (
    .temp_hires (temp_hires),
    .duty_hires (duty_hires),
    .freq_22k5  (freq_22k5),
    .limit_raw  (LIMIT_FIVE),
    .duty_raw   (r.duty_five),
    .offset     (r.ofs),
    .temp       (REMOTE_TEMP),
    .exceeded   (exceed_five),
    .duty_eff   (duty_eff_five)
  );

  flt_entry u_entry_six (
    .temp_hires (temp_hires),
    .duty_hires (duty_hires),
    .freq_22k5  (freq_22k5),
    .limit_raw  (r.temp_six),
    .duty_raw   (r.duty_six),
    .offset     (r.ofs),
    .temp       (REMOTE_TEMP),
    .exceeded   (exceed_six),
    .duty_eff   (duty_eff_six)
  );

  // read view: unused bits show zero in the low resolution modes
  function automatic logic [7:0] read_view(input logic [7:0] i);
    logic [7:0] v;
    v = 8'h00;
    case (i)
      IDX_TABLE_CTRL: v = r.ctrl;
      IDX_TEMP_OFS:   v = r.ofs;
      IDX_PWM_CFG:    v = r.pwm_cfg;
      IDX_DUTY_FIVE: begin
        v = r.duty_five;
        if (!duty_hires) begin
          v[DUTY_EXT_MSB:DUTY_EXT_LSB] = 2'b00;
        end
      end
      IDX_DUTY_SIX: begin
        v = r.duty_six;
        if (!duty_hires) begin
          v[DUTY_EXT_MSB:DUTY_EXT_LSB] = 2'b00;
        end
      end
      IDX_TEMP_SIX: begin
        v = r.temp_six;
        if (!temp_hires) begin
          v[LIMIT_HALF] = 1'b0;
        end
      end
      default: v = 8'h00;
    endcase
    return v;
  endfunction : read_view

  always_comb begin
    next_r = r;
    case (r.st)
      FLT_IDLE: begin
        // answer one cycle after the request, data latched here
        if (READ || WRITE) begin
          next_r.st      = FLT_RESP;
          next_r.waitreq = 1'b0;
          next_r.rdata   = READ ? read_view(idx) : 8'h00;
        end
      end
      FLT_RESP: begin
        // write lands on the edge where waitrequest is seen low
        next_r.st      = FLT_IDLE;
        next_r.waitreq = 1'b1;
        if (WRITE && wr_lane) begin
          case (idx)
            IDX_TABLE_CTRL: next_r.ctrl    = wbyte & CTRL_WMASK;
            IDX_TEMP_OFS:   next_r.ofs     = wbyte;
            IDX_PWM_CFG:    next_r.pwm_cfg = wbyte;
            IDX_DUTY_FIVE: begin
              if (unlocked) begin
                next_r.duty_five = wbyte;
              end
            end
            IDX_TEMP_SIX: begin
              if (unlocked) begin
                next_r.temp_six = wbyte;
              end
            end
            IDX_DUTY_SIX: begin
              if (unlocked) begin
                next_r.duty_six = wbyte;
              end
            end
            default: next_r.ctrl = r.ctrl;
          endcase
        end
      end
      default: begin
        next_r.st      = FLT_IDLE;
        next_r.waitreq = 1'b1;
      end
    endcase
    // higher entry wins when both limits are passed
    next_r.hit_five  = exceed_five;
    next_r.hit_six   = exceed_six;
    next_r.pwm_valid = exceed_five || exceed_six;
    if (exceed_six) begin
      next_r.pwm_duty = duty_eff_six;
    end else if (exceed_five) begin
      next_r.pwm_duty = duty_eff_five;
    end else begin
      next_r.pwm_duty = 8'h00;
    end
  end

  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      r.st        <= FLT_IDLE;
      r.waitreq   <= 1'b1;
      r.rdata     <= 8'h00;
      r.duty_five <= RST_DUTY_FIVE;
      r.temp_six  <= RST_TEMP_SIX;
      r.duty_six  <= RST_DUTY_SIX;
      r.ctrl      <= RST_CTRL;
      r.ofs       <= RST_OFS;
      r.pwm_cfg   <= RST_PWM_CFG;
      r.pwm_duty  <= 8'h00;
      r.pwm_valid <= 1'b0;
      r.hit_five  <= 1'b0;
      r.hit_six   <= 1'b0;
    end else begin
      r <= next_r;
    end
  end

  assign READDATA       = {24'h000000, r.rdata};
  assign WAITREQUEST    = r.waitreq;
  assign PWM_DUTY       = r.pwm_duty;
  assign PWM_VALID      = r.pwm_valid;
  assign LIMIT_FIVE_HIT = r.hit_five;
  assign LIMIT_SIX_HIT  = r.hit_six;

endmodule : flt_top
`default_nettype wire

// ### bench/flt_top_checker.sv
// flt_top_checker: bus and compare-output properties of flt_top.
// assumes it is bound to flt_top and watches only its ports.
`timescale 1ns/1ps
`default_nettype none
module flt_top_checker (
  input wire logic        CLOCK,          // clock
  input wire logic        NRST,           // reset, low
  input wire logic        READ,           // read request
  input wire logic        WRITE,          // write request
  input wire logic        WAITREQUEST,    // stall
  input wire logic [31:0] READDATA,       // read data
  input wire logic [8:0]  REMOTE_TEMP,    // temperature
  input wire logic [7:0]  LIMIT_FIVE,     // entry five limit
  input wire logic [7:0]  PWM_DUTY,       // duty out
  input wire logic        PWM_VALID,      // any hit
  input wire logic        LIMIT_FIVE_HIT, // entry five hit
  input wire logic        LIMIT_SIX_HIT   // entry six hit
);
  default clocking @(posedge CLOCK); endclocking
  default disable iff (!NRST);
  logic maybe_five;
  // offset only raises a limit, so a reading at or below the raw limit never hits
  always_ff @(posedge CLOCK) maybe_five <= REMOTE_TEMP > {LIMIT_FIVE[6:0], 1'b0};
  sequence s_take; (READ || WRITE) && WAITREQUEST; endsequence
  sequence s_answer; !WAITREQUEST ##1 WAITREQUEST; endsequence
  a_req_answer: assert property (s_take |=> s_answer)
    else $error("request not answered after one wait");
  a_wait_idle: assert property (!(READ || WRITE) && WAITREQUEST |=> WAITREQUEST)
    else $error("answer without request");
  a_answer_cause: assert property (!WAITREQUEST |-> $past(READ) || $past(WRITE))
    else $error("answer with no request taken");
  a_data_holds: assert property (WAITREQUEST && $past(WAITREQUEST) |-> $stable(READDATA))
    else $error("read data moved while idle");
  a_upper_zero: assert property (!WAITREQUEST |-> READDATA[31:8] == 24'h000000)
    else $error("read data upper bits set");
  a_valid_hits: assert property (PWM_VALID == (LIMIT_FIVE_HIT || LIMIT_SIX_HIT))
    else $error("valid disagrees with hits");
  a_idle_duty: assert property (!PWM_VALID |-> PWM_DUTY == 8'h00)
    else $error("duty without a hit");
  a_five_clear: assert property (!maybe_five |-> !LIMIT_FIVE_HIT)
    else $error("entry five hit at or below limit");
endmodule : flt_top_checker
bind flt_top flt_top_checker u_chk (.CLOCK(CLOCK), .NRST(NRST), .READ(READ),
  .WRITE(WRITE), .WAITREQUEST(WAITREQUEST), .READDATA(READDATA),
  .REMOTE_TEMP(REMOTE_TEMP), .LIMIT_FIVE(LIMIT_FIVE), .PWM_DUTY(PWM_DUTY),
  .PWM_VALID(PWM_VALID), .LIMIT_FIVE_HIT(LIMIT_FIVE_HIT), .LIMIT_SIX_HIT(LIMIT_SIX_HIT));
`default_nettype wire

// ### bench/flt_host.sv
// flt_host: system host model, one register access at a time.
// assumes an Avalon-MM slave with waitrequest on CLOCK.
`timescale 1ns/1ps
`default_nettype none
module flt_host (
  input  wire logic        CLOCK,       // clock
  output logic      [9:0]  ADDRESS,     // byte address
  output logic             READ,        // read request
  output logic             WRITE,       // write request
  output logic      [3:0]  BYTEENABLE,  // lanes
  output logic      [31:0] WRITEDATA,   // write data
  input  wire logic [31:0] READDATA,    // read data
  input  wire logic        WAITREQUEST  // stall
);
  initial {ADDRESS, READ, WRITE, BYTEENABLE, WRITEDATA} = {10'h000, 2'b00, 4'hF, 32'h0};
  // limit values handed in stay positive, top bit only as half step
  task acc(input logic w, input logic [3:0] lanes, input logic [7:0] idx,
    input logic [7:0] d, output logic [7:0] q);
    @(posedge CLOCK);
    ADDRESS    <= {idx, 2'b00};
    WRITEDATA  <= {24'h000000, d};
    BYTEENABLE <= lanes;
    READ      <= !w;
    WRITE     <= w;
    do @(posedge CLOCK); while (WAITREQUEST !== 1'b0);
    q = READDATA[7:0];
    READ      <= 1'b0;
    WRITE     <= 1'b0;
    // released address and data lines show junk, not the last value
    ADDRESS   <= ~ADDRESS;
    WRITEDATA <= ~WRITEDATA;
  endtask : acc
endmodule : flt_host
`default_nettype wire

// ### bench/flt_top_tb.sv
// flt_top_tb: table entries five and six, bus and compare scenarios.
// assumes flt_host drives the bus and flt_top_checker is bound.
`timescale 1ns/1ps
`default_nettype none
module flt_top_tb;
  import flt_pkg::*;
  logic clock = 0, nrst = 0;
  logic [8:0] temp = 9'h000;
  logic [7:0] lim5 = 8'h7F, q;
  wire logic [9:0] addr;
  wire logic rd, wr, wt, pv, h5, h6;
  wire logic [3:0] be;
  wire logic [31:0] wd, rdata;
  wire logic [7:0] duty;
  int num_errors = 0, checks = 0, cyc = 0;
  always #2.5 clock = ~clock;
  flt_host host (.CLOCK(clock), .ADDRESS(addr), .READ(rd), .WRITE(wr), .BYTEENABLE(be),
    .WRITEDATA(wd), .READDATA(rdata), .WAITREQUEST(wt));
  flt_top DUT (.CLOCK(clock), .NRST(nrst), .ADDRESS(addr), .READ(rd), .WRITE(wr),
    .BYTEENABLE(be), .WRITEDATA(wd), .READDATA(rdata), .WAITREQUEST(wt),
    .REMOTE_TEMP(temp), .LIMIT_FIVE(lim5), .PWM_DUTY(duty), .PWM_VALID(pv),
    .LIMIT_FIVE_HIT(h5), .LIMIT_SIX_HIT(h6));
  task chk(input logic [8:0] got, input logic [8:0] exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task w(input logic [7:0] i, input logic [7:0] d);
    host.acc(1'b1, 4'hF, i, d, q);
  endtask : w
  task r(input logic [7:0] i, input logic [7:0] e);
    host.acc(1'b0, 4'hF, i, 8'h00, q);
    chk(q, e);
  endtask : r
  // temperature moves on an edge; compare outputs lag one clock, so two edges settle them
  task cmp(input logic [8:0] t, input logic [7:0] e, input logic [1:0] hit);
    @(posedge clock);
    temp <= t;
    repeat (2) @(posedge clock);
    #1;
    chk(duty, e);
    chk(pv, |hit);
    chk({h6, h5}, hit);
  endtask : cmp
  task end_sim;
    $display("checks %0d num_errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : end_sim
  always @(posedge clock) begin
    cyc++;
    if (cyc == 2000) begin
      num_errors++;
      end_sim();
    end
  end
  task t_reset_values;
    r(IDX_DUTY_FIVE, 8'h3F);
    r(IDX_TEMP_SIX, 8'h7F);
    r(IDX_DUTY_SIX, 8'h3F);
  endtask : t_reset_values
  task t_lock;
    w(IDX_DUTY_SIX, 8'hC5);
    r(IDX_DUTY_SIX, 8'h3F);
    w(IDX_TABLE_CTRL, 8'h20);
    w(IDX_DUTY_SIX, 8'hC5);
    w(IDX_TEMP_SIX, 8'h85);
    // low lane off: this write must leave the limit alone
    host.acc(1'b1, 4'hE, IDX_TEMP_SIX, 8'h11, q);
    r(8'h33, 8'h00);
  endtask : t_lock
  task t_low_res;
    r(IDX_DUTY_SIX, 8'h05);
    r(IDX_TEMP_SIX, 8'h05);
    cmp(9'd11, 8'h00, 2'b00);
    cmp(9'd12, 8'h05, 2'b10);
  endtask : t_low_res
  task t_high_res;
    w(IDX_TABLE_CTRL, 8'h23);
    r(IDX_DUTY_SIX, 8'hC5);
    r(IDX_TEMP_SIX, 8'h85);
    cmp(9'd12, 8'h05, 2'b10);
    w(IDX_PWM_CFG, {5'h00, PWM_FREQ_22K5});
    cmp(9'd11, 8'h00, 2'b00);
    cmp(9'd12, 8'hC5, 2'b10);
  endtask : t_high_res
  task t_offset;
    w(IDX_TEMP_OFS, 8'h01);
    cmp(9'd13, 8'h00, 2'b00);
    cmp(9'd14, 8'hC5, 2'b10);
    @(posedge clock);
    lim5 <= 8'h00;
    cmp(9'd3, 8'h3F, 2'b01);
  endtask : t_offset
  task t_range;
    w(IDX_TEMP_OFS, 8'h00);
    w(IDX_TEMP_SIX, 8'hFF);
    cmp(9'd511, 8'hC5, 2'b11);
    cmp(9'd255, 8'h3F, 2'b01);
  endtask : t_range
  // reset in mid-run brings back the defaults, including low resolution
  task t_reset_mid;
    @(posedge clock);
    nrst <= 1'b0;
    repeat (2) @(posedge clock);
    nrst <= 1'b1;
    r(IDX_TEMP_SIX, 8'h7F);
    r(IDX_DUTY_SIX, 8'h3F);
    r(IDX_TABLE_CTRL, 8'h00);
    cmp(9'd255, 8'h3F, 2'b01);
  endtask : t_reset_mid
  initial begin
    repeat (6) @(posedge clock);
    nrst <= 1'b1;
    t_reset_values();
    t_lock();
    t_low_res();
    t_high_res();
    t_offset();
    t_range();
    t_reset_mid();
    end_sim();
  end
endmodule : flt_top_tb
`default_nettype wire
